// File: dv/vectored_interrupt_handler_bench.sv
`timescale 1ns/10ps
`default_nettype none
module vectored_interrupt_handler_bench;
    import vih_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic we = 1'b0;
    logic re = 1'b0;
    logic [8:0] evt = 9'h000;
    logic pin0 = 1'b1;
    logic pin1 = 1'b1;
    logic ret_cmd = 1'b0;
    logic ack, return_from_irq_instr, idone, req, insvc;
    logic [7:0] rdata, n_calls;
    logic [15:0] vec, last_vec;
    int fails = 0;
    int n_tests = 0;
    logic [7:0] seen_calls = 8'h00;

    always #5 clk = ~clk;

    vih_handler dut_u (.i_ref_clk(clk), .i_rst(rst), .i_sfr_addr(addr), .i_sfr_wdata(wdata),
        .i_sfr_we(we), .i_sfr_re(re), .i_periph_evt(evt), .i_ext_irq0_n_pin(pin0),
        .i_ext_irq1_n_pin(pin1), .i_vec_ack(ack), .i_return_from_irq_instr(return_from_irq_instr), .i_instr_done(idone),
        .o_sfr_rdata(rdata), .o_irq_req(req), .o_irq_vector(vec), .o_in_service(insvc));

    vih_core_model core_u (.i_ref_clk(clk), .i_rst(rst), .i_irq_req(req),
        .i_irq_vector(vec), .i_ret_cmd(ret_cmd), .o_vec_ack(ack), .o_return_from_irq_instr(return_from_irq_instr),
        .o_instr_done(idone), .o_last_vec(last_vec), .o_n_calls(n_calls));

    ////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        if (fails == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : give_verdict

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        we <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
    endtask : sfr_wr

    task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        re <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        @(posedge clk);
        d = rdata;
    endtask : sfr_rd

    // bounded: a call that never comes ends the run
    task automatic wait_call();
        int i;
        for (i = 0; i < 200 && n_calls === seen_calls; i++)
            @(posedge clk);
        if (n_calls === seen_calls)
        begin
            fails++;
            give_verdict();
        end
        seen_calls = n_calls;
    endtask : wait_call

    task automatic ret();
        int i;
        @(posedge clk);
        ret_cmd <= 1'b1;
        @(posedge clk);
        ret_cmd <= 1'b0;
        for (i = 0; i < 50 && insvc !== 1'b0; i++)
            @(posedge clk);
        if (insvc !== 1'b0)
        begin
            fails++;
            give_verdict();
        end
    endtask : ret

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [7:0] d;
        check("req", {15'h0, req}, 16'h0000);
        sfr_rd(ADDR_SWI, d);
        check("swi", {8'h0, d}, 16'h0000);
        sfr_rd(ADDR_IE, d);
        check("ie", {8'h0, d}, 16'h0000);
    endtask : t_reset

    task automatic t_soft();
        logic [7:0] d;
        sfr_wr(ADDR_SWI, 8'hff);
        sfr_rd(ADDR_SWI, d);
        check("swi", {8'h0, d}, 16'h00f0);
        sfr_rd(ADDR_PND2, d);
        check("pnd2", {8'h0, d}, 16'h000f);
        sfr_wr(ADDR_EXTENDED_ENABLE_REG2, 8'h04);
        repeat (4) @(posedge clk);
        check("req no gie", {15'h0, req}, 16'h0000);
        sfr_wr(ADDR_IE, 8'h80);
        wait_call();
        check("vec soft0", last_vec, 16'h0083);
        sfr_rd(ADDR_SWI, d);
        check("swi kept", {8'h0, d}, 16'h00f0);
        ret();
        wait_call();
        check("vec again", last_vec, 16'h0083);
        sfr_wr(ADDR_SWI, 8'h00);
        ret();
        sfr_wr(ADDR_IE, 8'h00);
        sfr_wr(ADDR_SWI, 8'h10);
        repeat (4) @(posedge clk);
        check("req gie off", {15'h0, req}, 16'h0000);
        sfr_wr(ADDR_SWI, 8'h00);
    endtask : t_soft

    task automatic t_ext();
        logic [7:0] d;
        sfr_wr(ADDR_TIMER_CTRL_REG, 8'h01);
        sfr_wr(ADDR_IE, 8'h81);
        @(posedge clk);
        pin0 <= 1'b0;
        wait_call();
        check("vec ext0", last_vec, 16'h0003);
        pin0 <= 1'b1;
        sfr_rd(ADDR_TIMER_CTRL_REG, d);
        check("timer_ctrl_reg edge", {8'h0, d}, 16'h0001);
        ret();
        sfr_wr(ADDR_TIMER_CTRL_REG, 8'h00);
        // ext1 stays disabled, so its held level raises nothing
        pin1 <= 1'b0;
        repeat (3) @(posedge clk);
        sfr_rd(ADDR_TIMER_CTRL_REG, d);
        check("timer_ctrl_reg lvl", {8'h0, d}, 16'h0008);
        check("req ext1 off", {15'h0, req}, 16'h0000);
        pin1 <= 1'b1;
        repeat (2) @(posedge clk);
        sfr_rd(ADDR_TIMER_CTRL_REG, d);
        check("timer_ctrl_reg lvl off", {8'h0, d}, 16'h0000);
        pin0 <= 1'b0;
        wait_call();
        check("vec lvl0", last_vec, 16'h0003);
        pin0 <= 1'b1; // held until taken, then let go
        ret();
        repeat (8) @(posedge clk);
        check("no lvl recall", {8'h0, n_calls}, {8'h0, seen_calls});
    endtask : t_ext

    task automatic t_periph();
        sfr_wr(ADDR_IE, 8'h8a);
        @(posedge clk);
        evt <= 9'h003;
        @(posedge clk);
        evt <= 9'h000;
        wait_call();
        check("vec first", last_vec, 16'h000b);
        sfr_wr(ADDR_PND0, 8'h08);
        ret();
        wait_call();
        check("vec second", last_vec, 16'h001b);
        sfr_wr(ADDR_PND0, 8'h00);
        ret();
        sfr_wr(ADDR_IE, 8'h00);
    endtask : t_periph

    task automatic t_prio();
        logic [7:0] d;
        sfr_wr(ADDR_EIP2, 8'h04);
        sfr_rd(ADDR_EIP2, d);
        check("eip2", {8'h0, d}, 16'h0004);
        sfr_wr(ADDR_EXTENDED_ENABLE_REG2, 8'h04);
        sfr_wr(ADDR_IE, 8'h82);
        @(posedge clk);
        evt <= 9'h001;
        @(posedge clk);
        evt <= 9'h000;
        wait_call();
        check("vec low", last_vec, 16'h000b);
        sfr_wr(ADDR_SWI, 8'h10);
        wait_call();
        check("vec preempt", last_vec, 16'h0083);
        repeat (8) @(posedge clk);
        check("req in high", {15'h0, req}, 16'h0000);
        sfr_wr(ADDR_SWI, 8'h00);
        @(posedge clk);
        ret_cmd <= 1'b1;
        @(posedge clk);
        ret_cmd <= 1'b0;
        repeat (8) @(posedge clk);
        check("low kept", {15'h0, insvc}, 16'h0001);
        check("no recall", {8'h0, n_calls}, {8'h0, seen_calls});
        sfr_wr(ADDR_PND0, 8'h00);
        ret();
        sfr_wr(ADDR_IE, 8'h00);
        sfr_wr(ADDR_EXTENDED_ENABLE_REG2, 8'h00);
        sfr_wr(ADDR_EIP2, 8'h00);
    endtask : t_prio

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_soft();
        t_ext();
        t_periph();
        t_prio();
        give_verdict();
    end
endmodule : vectored_interrupt_handler_bench
`default_nettype wire

// File: dv/vih_core_model.sv
`timescale 1ns/10ps
`default_nettype none
module vih_core_model (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_irq_req,
    input wire logic [15:0] i_irq_vector,
    input wire logic i_ret_cmd,
    output logic o_vec_ack,
    output logic o_return_from_irq_instr,
    output logic o_instr_done,
    output logic [15:0] o_last_vec,
    output logic [7:0] o_n_calls
);
    logic [1:0] cnt;
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            cnt <= 2'h0;
            o_vec_ack <= 1'b0;
            o_return_from_irq_instr <= 1'b0;
            o_instr_done <= 1'b0;
            o_last_vec <= 16'h0000;
            o_n_calls <= 8'h00;
        end
        else
        begin
            cnt <= cnt + 2'h1;
            // slow core: an instruction ends only every fourth clock
            o_instr_done <= (cnt == 2'h3);
            // call taken only once the running instruction is over
            o_vec_ack <= i_irq_req && (cnt == 2'h3) && !o_vec_ack;
            // return resumes the interrupted flow
            o_return_from_irq_instr <= i_ret_cmd;
            if (o_vec_ack)
            begin
                o_last_vec <= i_irq_vector;
                o_n_calls <= o_n_calls + 8'h01;
            end
        end
    end
endmodule : vih_core_model
`default_nettype wire

// File: rtl/vih_handler.sv
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - a source meeting its trigger condition sets its pending flag
// - pending flags set regardless of enable state
// - enabled pending source raises request; core calls its fixed vector
// - return resumes the interrupted flow; core side, signalled by return pulse
// - disabled source: flag ignored, no request
// - every source has its own enable bit
// - individual enables count only while global enable bit 7 is one
// - global enable zero blocks every source
// - flag still set after return: request again after one more instruction
// - 22 sources, each low or high priority
// - nine sources belong to on-chip peripherals
// - software writing one to a pending flag acts as a real event, except a level mode external flag
// - external inputs active low, level or falling edge by select bits 0 and 2
// - external pending flags at timer control bits 1 and 3
// - edge mode external flag clears when core vectors
// - level mode external flag follows the pin, never latched
// - software flags in bits 7..4; writing one vectors to own routine
// - software flags never cleared by hardware
// - low four bits of software register read zero, ignore writes
// - high preempts low; high never preempted; low after reset
// - equal priority resolved by fixed source order
// - sampled every clock; request one cycle after detection
module vih_handler
    import vih_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic [7:0] i_sfr_addr,
    input wire logic [7:0] i_sfr_wdata,
    input wire logic i_sfr_we,
    input wire logic i_sfr_re,
    input wire logic [NPERIPH-1:0] i_periph_evt,
    input wire logic i_ext_irq0_n_pin,
    input wire logic i_ext_irq1_n_pin,
    input wire logic i_vec_ack,
    input wire logic i_return_from_irq_instr,
    input wire logic i_instr_done,
    output logic [7:0] o_sfr_rdata,
    output logic o_irq_req,
    output logic [15:0] o_irq_vector,
    output logic o_in_service
);

////////////////////////////////////////////////////////////////////////////////

    vih_state_s s;
    vih_state_s next_s;

    function automatic logic [7:0] win_rd(logic [21:0] v, int unsigned base, logic [7:0] m);
        logic [7:0] r;
        r = 8'h00;
        for (int unsigned i = 0; i < 8; i++)
        begin
            if (m[i] && (base + i) < NSRC)
            begin
                r[i] = v[base+i];
            end
        end
        return r;
    endfunction : win_rd

    function automatic logic [21:0] win_wr(logic [21:0] v, int unsigned base, logic [7:0] m,
                                           logic [7:0] d);
        logic [21:0] r;
        r = v;
        for (int unsigned i = 0; i < 8; i++)
        begin
            if (m[i] && (base + i) < NSRC)
            begin
                r[base+i] = d[i];
            end
        end
        return r;
    endfunction : win_wr

    // lowest index wins among equals
    function automatic logic [5:0] pick(logic [21:0] m);
        logic [5:0] r;
        r = 6'h00;
        for (int i = NSRC - 1; i >= 0; i--)
        begin
            if (m[i])
            begin
                r = {1'b1, 5'(i)};
            end
        end
        return r;
    endfunction : pick

////////////////////////////////////////////////////////////////////////////////

    logic [21:0] eff;
    logic [21:0] ok;
    logic [5:0] sel_hi;
    logic [5:0] sel_lo;
    logic [1:0] fall;
    logic [1:0] pin;

    always_comb
    begin
        pin = {i_ext_irq1_n_pin, i_ext_irq0_n_pin};
        fall = s.pin_q & ~pin;
        eff = s.pend;
        // level mode: flag is the inverted pin itself, nothing latched
        if (!s.edge_sel[0])
        begin
            eff[SRC_EXT0] = ~pin[0];
        end
        if (!s.edge_sel[1])
        begin
            eff[SRC_EXT1] = ~pin[1];
        end
        ok = eff & s.en & {NSRC{s.gie}};
        sel_hi = pick(ok & s.prio);
        sel_lo = pick(ok & ~s.prio);
    end

    always_comb
    begin
        logic [21:0] setv;
        logic [7:0] tc;
        setv = RST_VEC;
        tc = 8'h00;
        next_s = s;
        next_s.pin_q = pin;
        for (int unsigned k = 0; k < NPERIPH; k++)
        begin
            setv[PERIPH_SRC[k]] = i_periph_evt[k];
        end
        setv[SRC_EXT0] = s.edge_sel[0] & fall[0];
        setv[SRC_EXT1] = s.edge_sel[1] & fall[1];
        tc = {s.timer_ctrl_reg_hi, eff[SRC_EXT1], s.edge_sel[1], eff[SRC_EXT0], s.edge_sel[0]};
        if (i_sfr_re)
        begin
            unique case (i_sfr_addr)
                ADDR_TIMER_CTRL_REG: next_s.rdata = tc;
                ADDR_IE: next_s.rdata = win_rd(s.en, BASE_A, MASK_A) | {s.gie, 7'h00};
                ADDR_EIE1: next_s.rdata = win_rd(s.en, BASE_B, MASK_B);
                ADDR_EXTENDED_ENABLE_REG2: next_s.rdata = win_rd(s.en, BASE_C, MASK_C);
                ADDR_IP: next_s.rdata = win_rd(s.prio, BASE_A, MASK_A);
                ADDR_EIP1: next_s.rdata = win_rd(s.prio, BASE_B, MASK_B);
                ADDR_EIP2: next_s.rdata = win_rd(s.prio, BASE_C, MASK_C);
                ADDR_PND0: next_s.rdata = win_rd(eff, BASE_A, MASK_B);
                ADDR_PND1: next_s.rdata = win_rd(eff, PBASE_B, MASK_B);
                ADDR_PND2: next_s.rdata = win_rd(eff, PBASE_C, PMASK_C);
                ADDR_SWI: next_s.rdata = {s.pend[SRC_SOFT0+3:SRC_SOFT0], 4'h0};
                default: next_s.rdata = RST_BYTE;
            endcase
        end
        if (i_sfr_we)
        begin
            unique case (i_sfr_addr)
                ADDR_TIMER_CTRL_REG:
                begin
                    next_s.edge_sel = {i_sfr_wdata[EDGE1_BIT], i_sfr_wdata[EDGE0_BIT]};
                    next_s.timer_ctrl_reg_hi = i_sfr_wdata[7:4];
                    next_s.pend[SRC_EXT0] = i_sfr_wdata[PEND0_BIT];
                    next_s.pend[SRC_EXT1] = i_sfr_wdata[PEND1_BIT];
                end
                ADDR_IE:
                begin
                    next_s.gie = i_sfr_wdata[GIE_BIT];
                    next_s.en = win_wr(s.en, BASE_A, MASK_A, i_sfr_wdata);
                end
                ADDR_EIE1: next_s.en = win_wr(s.en, BASE_B, MASK_B, i_sfr_wdata);
                ADDR_EXTENDED_ENABLE_REG2: next_s.en = win_wr(s.en, BASE_C, MASK_C, i_sfr_wdata);
                ADDR_IP: next_s.prio = win_wr(s.prio, BASE_A, MASK_A, i_sfr_wdata);
                ADDR_EIP1: next_s.prio = win_wr(s.prio, BASE_B, MASK_B, i_sfr_wdata);
                ADDR_EIP2: next_s.prio = win_wr(s.prio, BASE_C, MASK_C, i_sfr_wdata);
                ADDR_PND0: next_s.pend = win_wr(s.pend, BASE_A, MASK_B, i_sfr_wdata);
                ADDR_PND1: next_s.pend = win_wr(s.pend, PBASE_B, MASK_B, i_sfr_wdata);
                ADDR_PND2: next_s.pend = win_wr(s.pend, PBASE_C, PMASK_C, i_sfr_wdata);
                // low nibble has no storage
                ADDR_SWI: next_s.pend[SRC_SOFT0+3:SRC_SOFT0] = i_sfr_wdata[7:SWI_LSB];
                default:
                begin
                end
            endcase
        end
        if (i_vec_ack && s.req)
        begin
            next_s.req = 1'b0;
            if (s.req_src == 5'(SRC_EXT0) && s.edge_sel[0])
            begin
                next_s.pend[SRC_EXT0] = 1'b0;
            end
            if (s.req_src == 5'(SRC_EXT1) && s.edge_sel[1])
            begin
                next_s.pend[SRC_EXT1] = 1'b0;
            end
            if (s.prio[s.req_src])
            begin
                next_s.in_svc_hi = 1'b1;
            end
            else
            begin
                next_s.in_svc_lo = 1'b1;
            end
        end
        // a new event in the clearing cycle survives; soft flags only clear by write
        next_s.pend = next_s.pend | setv;
        if (i_return_from_irq_instr)
        begin
            // one instruction must run before the next call
            next_s.holdoff = 1'b1;
            if (s.in_svc_hi)
            begin
                next_s.in_svc_hi = 1'b0;
            end
            else
            begin
                next_s.in_svc_lo = 1'b0;
            end
        end
        else if (i_instr_done)
        begin
            next_s.holdoff = 1'b0;
        end
        next_s.in_svc_any = next_s.in_svc_lo | next_s.in_svc_hi;
        // request tracks the arbiter every clock until the core takes it
        if (!(i_vec_ack && s.req))
        begin
            next_s.req = 1'b0;
            if (!s.holdoff && !i_return_from_irq_instr && !s.in_svc_hi)
            begin
                if (sel_hi[5])
                begin
                    next_s.req = 1'b1;
                    next_s.req_src = sel_hi[4:0];
                end
                else if (sel_lo[5] && !s.in_svc_lo)
                begin
                    next_s.req = 1'b1;
                    next_s.req_src = sel_lo[4:0];
                end
            end
            next_s.vec = VEC_BASE + {8'h00, next_s.req_src, 3'b000};
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            s <= '0; // low priority, all disabled
            s.pin_q <= 2'b11;
            s.vec <= VEC_BASE;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign o_sfr_rdata = s.rdata;
    assign o_irq_req = s.req;
    assign o_irq_vector = s.vec;
    assign o_in_service = s.in_svc_any;

////////////////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);

    // high priority soft source pending and free to be taken
    sequence seq_ready_hi;
        ok[SRC_SOFT0] && s.prio[SRC_SOFT0] && !s.holdoff && !s.in_svc_hi && !i_return_from_irq_instr && !s.req;
    endsequence

    sequence seq_taken;
        o_irq_req && i_vec_ack;
    endsequence

    sequence seq_lo_busy;
        s.in_svc_lo && !s.in_svc_hi;
    endsequence

    chk_req_response: assert property (seq_ready_hi |=> o_irq_req)
        else $error("ready high request not raised next cycle");

    chk_hi_preempt: assert property ((seq_ready_hi and seq_lo_busy) |=> o_irq_req)
        else $error("high request held back by low routine");

    chk_lo_blocked: assert property (
        (seq_lo_busy and ((ok & s.prio) == 22'h000000)) |=> !o_irq_req)
        else $error("low request inside low routine");

    chk_gie_blocks: assert property (!s.gie |=> !o_irq_req)
        else $error("request raised with global enable off");

    chk_req_enabled: assert property (
        o_irq_req && !$past(i_vec_ack) |-> $past(s.en) != 22'h000000 && $past(s.gie))
        else $error("request without any enabled source");

    chk_vec_addr: assert property (
        o_irq_req |-> o_irq_vector == 16'(VEC_BASE + VEC_STEP * s.req_src))
        else $error("vector does not match requesting source");

    chk_periph_set: assert property (i_periph_evt[0] |=> s.pend[PERIPH_SRC[0]])
        else $error("peripheral event lost");

    chk_soft_set: assert property (
        i_sfr_we && i_sfr_addr == ADDR_PND0 && i_sfr_wdata[PERIPH_SRC[1]] |=> s.pend[PERIPH_SRC[1]])
        else $error("software set of pending flag lost");

    chk_edge_sets: assert property (
        s.edge_sel[0] && s.pin_q[0] && !i_ext_irq0_n_pin |=> s.pend[SRC_EXT0])
        else $error("falling edge not latched");

    chk_edge_clear: assert property (
        (seq_taken and (s.req_src == 5'(SRC_EXT0) && s.edge_sel[0] && !fall[0] && !i_sfr_we))
        |=> !s.pend[SRC_EXT0])
        else $error("edge flag not cleared on vector");

    chk_level_read: assert property (
        !s.edge_sel[0] && !i_sfr_we && i_sfr_re && i_sfr_addr == ADDR_TIMER_CTRL_REG
        |=> o_sfr_rdata[PEND0_BIT] == !$past(i_ext_irq0_n_pin))
        else $error("level flag does not follow pin");

    chk_swi_low_zero: assert property (
        i_sfr_re && i_sfr_addr == ADDR_SWI |=> o_sfr_rdata[3:0] == 4'h0)
        else $error("software register low bits not zero");

    chk_swi_write: assert property (
        i_sfr_we && i_sfr_addr == ADDR_SWI
        |=> s.pend[SRC_SOFT0+3:SRC_SOFT0] == $past(i_sfr_wdata[7:SWI_LSB]))
        else $error("software flags not written");

    chk_soft_sticky: assert property (
        s.pend[SRC_SOFT0] && !i_sfr_we |=> s.pend[SRC_SOFT0])
        else $error("software flag cleared by hardware");

    chk_hi_no_preempt: assert property (s.in_svc_hi && !i_return_from_irq_instr |=> !o_irq_req)
        else $error("high priority routine preempted");

    chk_ret_clears: assert property (
        i_return_from_irq_instr && s.in_svc_hi && !i_vec_ack |=> !s.in_svc_hi)
        else $error("return left high routine in service");

    chk_return_from_irq_instr_holdoff: assert property (
        i_return_from_irq_instr ##1 !i_instr_done |-> !o_irq_req ##1 !o_irq_req)
        else $error("request before one instruction after return");

endmodule : vih_handler
`default_nettype wire

// File: rtl/vih_pkg.sv
`default_nettype none
package vih_pkg;
    localparam int unsigned NSRC = 22;
    localparam int unsigned NPERIPH = 9;
    // special function register addresses
    localparam logic [7:0] ADDR_TIMER_CTRL_REG = 8'h88;
    localparam logic [7:0] ADDR_PND0 = 8'h91;
    localparam logic [7:0] ADDR_PND1 = 8'h92;
    localparam logic [7:0] ADDR_PND2 = 8'h93;
    localparam logic [7:0] ADDR_IE = 8'ha8;
    localparam logic [7:0] ADDR_SWI = 8'had;
    localparam logic [7:0] ADDR_IP = 8'hb8;
    localparam logic [7:0] ADDR_EIE1 = 8'he6;
    localparam logic [7:0] ADDR_EXTENDED_ENABLE_REG2 = 8'he7;
    localparam logic [7:0] ADDR_EIP1 = 8'hf6;
    localparam logic [7:0] ADDR_EIP2 = 8'hf7;
    // windows of the 22-bit source vectors seen through 8-bit registers
    localparam int unsigned BASE_A = 0;
    localparam int unsigned BASE_B = 7;
    localparam int unsigned BASE_C = 14;
    localparam logic [7:0] MASK_A = 8'h7f;
    localparam logic [7:0] MASK_B = 8'hff;
    localparam logic [7:0] MASK_C = 8'hfe;
    localparam int unsigned PBASE_B = 8;
    localparam int unsigned PBASE_C = 16;
    localparam logic [7:0] PMASK_C = 8'h3f;
    // field positions
    localparam int unsigned GIE_BIT = 7;
    localparam int unsigned EDGE0_BIT = 0;
    localparam int unsigned PEND0_BIT = 1;
    localparam int unsigned EDGE1_BIT = 2;
    localparam int unsigned PEND1_BIT = 3;
    localparam int unsigned SWI_LSB = 4;
    localparam int unsigned SRC_EXT0 = 0;
    localparam int unsigned SRC_EXT1 = 2;
    localparam int unsigned SRC_SOFT0 = 16;
    localparam int unsigned PERIPH_SRC [NPERIPH] = '{1, 3, 4, 5, 6, 8, 10, 11, 15};
    localparam logic [15:0] VEC_BASE = 16'h0003;
    localparam logic [15:0] VEC_STEP = 16'h0008;
    localparam logic [21:0] RST_VEC = 22'h000000;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam int unsigned DETECT_CYCLES = 1;

    typedef struct packed {
        logic [21:0] pend;
        logic [21:0] en;
        logic [21:0] prio;
        logic gie;
        logic [1:0] edge_sel;
        logic [1:0] pin_q;
        logic [3:0] timer_ctrl_reg_hi;
        logic in_svc_lo;
        logic in_svc_hi;
        logic in_svc_any;
        logic holdoff;
        logic req;
        logic [4:0] req_src;
        logic [15:0] vec;
        logic [7:0] rdata;
    } vih_state_s;
endpackage : vih_pkg
`default_nettype wire
